// >>> gpp_bank.sv
// Purpose: Configuration and reset defaults of 32 shared programmable pins, APB slave
// Assumes: One clock pclk at 250 MHz, asynchronous active-low presetn
// Notes: Strap sampled after reset release; pads resolved by the pad ring
//
// Operation
// - Thirty-two pins, each configured independently
// - Per pin: function, direction, pull select
// - Reset: most pins input with pullup
// - Three high address pins keep normal function
// - Pins 4, 5, 6 keep normal function
// - Strap low returns pins 26, 29
// - Pins 4,5,7,8,9 offer pullup in pin mode
// - Pin 6 offers pulldown in pin mode
// - Strap sampled at the third enabled clock edge after reset release
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "gpp_defs.svh"
module gpp_bank #(
	parameter int NPINS = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic addr_strap_n,
	output gpp_pkg::gpp_pad_t pad,
	output logic [NPINS-1:0] general_purpose_pin_en
);
	localparam int STRAP_CYC = (`GPP_STRAP_DELAY_NS + `GPP_CLK_PERIOD_NS - 1) / `GPP_CLK_PERIOD_NS;

	// ****************************************
	// Strap capture
	// ****************************************
	logic strap_s1;
	logic strap_s2;
	logic strap_low;
	logic [3:0] strap_cnt;
	gpp_pkg::gpp_state_t state;
	gpp_pkg::gpp_state_t next_state;

	// Reset to the strap's pullup level so release never shows a false low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_s1 <= 1'b1;
			strap_s2 <= 1'b1;
		end else if (clk_en) begin
			strap_s1 <= addr_strap_n;
			strap_s2 <= strap_s1;
		end
	end

	wire sample_now = (state == gpp_pkg::GPP_ST_SAMPLE);

	always_comb begin
		case (state)
			gpp_pkg::GPP_ST_WAIT: next_state = (strap_cnt >= 4'(STRAP_CYC)) ? gpp_pkg::GPP_ST_SAMPLE : state;
			gpp_pkg::GPP_ST_SAMPLE: next_state = gpp_pkg::GPP_ST_RUN;
			gpp_pkg::GPP_ST_RUN: next_state = gpp_pkg::GPP_ST_RUN;
			default: next_state = gpp_pkg::GPP_ST_WAIT;
		endcase
	end

	// Sample is held for good once taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= gpp_pkg::GPP_ST_WAIT;
			strap_cnt <= 4'h0;
			strap_low <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			if (state == gpp_pkg::GPP_ST_WAIT)
				strap_cnt <= strap_cnt + 4'h1;
			if (sample_now)
				strap_low <= ~strap_s2;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [31:0] cfg_enable;
	logic [31:0] cfg_dir;
	logic [31:0] cfg_pull;
	logic [31:0] cfg_out;
	logic [NPINS-1:0] pin_sync;

	wire wr_access = psel && penable && pwrite;
	wire hit_enable = (paddr == `GPP_OFF_ENABLE);
	wire hit_dir = (paddr == `GPP_OFF_DIR);
	wire hit_pull = (paddr == `GPP_OFF_PULL);
	wire hit_out = (paddr == `GPP_OFF_OUT);
	wire hit_in = (paddr == `GPP_OFF_IN);
	wire hit_stat = (paddr == `GPP_OFF_STAT);
	wire hit_any = hit_enable | hit_dir | hit_pull | hit_out | hit_in | hit_stat;
	// Strap-driven revert of pins 26 and 29, applied once, at the same edge that takes the sample
	wire [31:0] strap_clear = sample_now && !strap_s2 ? `GPP_STRAP_MASK : 32'h00000000;

	// A software write to ENABLE wins over the strap revert in the same cycle
	// Each pin bit stands alone; writes touch whole words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_enable <= `GPP_RST_ENABLE;
			cfg_dir <= `GPP_RST_DIR;
			cfg_pull <= `GPP_RST_PULL;
			cfg_out <= `GPP_RST_OUT;
		end else if (clk_en) begin
			if (wr_access && hit_enable)
				cfg_enable <= pwdata;
			else
				cfg_enable <= cfg_enable & ~strap_clear;
			if (wr_access && hit_dir)
				cfg_dir <= pwdata;
			if (wr_access && hit_pull)
				cfg_pull <= pwdata;
			if (wr_access && hit_out)
				cfg_out <= pwdata;
		end
	end

	gpp_sync #(
		.WIDTH(NPINS)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// ****************************************
	// Bus answer
	// ****************************************
	wire [31:0] stat_word = (32'(strap_low) << `GPP_STAT_STRAP_BIT) |
		(32'(state == gpp_pkg::GPP_ST_RUN) << `GPP_STAT_DONE_BIT);
	wire [31:0] rd_mux = hit_enable ? cfg_enable :
		hit_dir ? cfg_dir :
		hit_pull ? cfg_pull :
		hit_out ? cfg_out :
		hit_in ? pin_sync :
		hit_stat ? stat_word : 32'h00000000;
	// Read-only words take writes silently; only unmapped offsets answer with an error
	// Answer after one wait state so prdata can come from a flop

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit_any;
			if (psel && penable && !pready && !pwrite)
				prdata <= rd_mux;
		end
	end

	// ****************************************
	// Pad drive
	// ****************************************
	// Pin mode: output drives out; pull only on inputs. Normal-function pins leave pads to other logic.
	// Pull select is passed through for outputs too; pull_en gates it at the pad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad <= '0;
			general_purpose_pin_en <= '0;
		end else if (clk_en) begin
			general_purpose_pin_en <= cfg_enable[NPINS-1:0];
			pad.out <= cfg_out;
			pad.oe <= cfg_enable & cfg_dir;
			pad.pull_en <= cfg_enable & ~cfg_dir;
			pad.pull_up <= cfg_pull;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Reset defaults are checked at the first edge after release

	rst_defaults_a: assert property (@(posedge pclk) $rose(presetn) |->
		cfg_enable[0] && !cfg_dir[0] && cfg_pull[0] && cfg_enable[31]) else $error("reset default wrong");
	addr_normal_a: assert property (@(posedge pclk) $rose(presetn) |->
		cfg_enable[9:7] == 3'b000) else $error("address pins not normal");
	ctl_normal_a: assert property (@(posedge pclk) $rose(presetn) |->
		cfg_enable[6:4] == 3'b000) else $error("control pins not normal");
	strap_revert_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sample_now && !strap_s2 && !wr_access |=> cfg_enable[26] == 1'b0 && cfg_enable[29] == 1'b0)
		else $error("strap revert missing");
	pull_up_a: assert property (@(posedge pclk) $rose(presetn) |->
		cfg_pull[5:4] == 2'b11 && cfg_pull[9:7] == 3'b111) else $error("pullup option wrong");
	pull_down_a: assert property (@(posedge pclk) $rose(presetn) |->
		cfg_pull[6] == 1'b0) else $error("pin 6 pull wrong");
	strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == gpp_pkg::GPP_ST_RUN && clk_en |=> $stable(strap_low)) else $error("strap value moved");
	pin_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en [*3] ##0 ($past(presetn) && $past(presetn, 2)) |-> pin_sync == $past(pin_in, 2))
		else $error("sync latency wrong");
	indep_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr_access && hit_dir && !pready |=> cfg_dir == $past(pwdata)) else $error("dir write lost");
	pready_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && psel && penable && !pready |=> pready) else $error("no answer");
	slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && psel && penable && !pready && !hit_any |=> pslverr && pready) else $error("no error answer");
	bad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr_access && !hit_any |=> $stable(cfg_dir) && $stable(cfg_pull) && $stable(cfg_out))
		else $error("unmapped write landed");
	// A low enable must leave enable, direction, pads, state and pready as they were
	freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(cfg_enable) && $stable(cfg_dir) && $stable(pad) && $stable(state) && $stable(pready))
		else $error("state moved while frozen");

	// ****************************************
	// Scenarios
	// ****************************************
	strap_low_c: cover property (@(posedge pclk) disable iff (!presetn) sample_now && !strap_s2);
	read_in_c: cover property (@(posedge pclk) disable iff (!presetn) pready && hit_in && !pwrite);
	bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
	freeze_c: cover property (@(posedge pclk) disable iff (!presetn) !clk_en && psel && penable);
	wr_enable_c: cover property (@(posedge pclk) disable iff (!presetn) pready && pwrite && hit_enable);
endmodule

// >>> gpp_defs.svh
// Purpose: Constants for the programmable pin bank (offsets, fields, reset values, timing)
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define GPP_OFF_ENABLE 12'h000
`define GPP_OFF_DIR 12'h004
`define GPP_OFF_PULL 12'h008
`define GPP_OFF_OUT 12'h00c
`define GPP_OFF_IN 12'h010
`define GPP_OFF_STAT 12'h014

// ****************************************
// Reset values
// ****************************************
// Pins 4..9 keep their normal function; every other pin is a pin-mode input
`define GPP_RST_ENABLE 32'hfffffc0f
`define GPP_RST_DIR 32'h00000000
// Pull bit 1 is pullup, 0 is pulldown; pins 1, 6 and 10 pull down
`define GPP_RST_PULL 32'hfffffbbd
`define GPP_RST_OUT 32'h00000000
// Pins handed back to normal function when the strap is low
`define GPP_STRAP_MASK 32'h24000000

// ****************************************
// Field positions
// ****************************************
`define GPP_STAT_STRAP_BIT 0
`define GPP_STAT_DONE_BIT 1

// ****************************************
// Timing
// ****************************************
`define GPP_STRAP_DELAY_NS 4
`define GPP_CLK_PERIOD_NS 4
`endif

// >>> gpp_pkg.sv
// Purpose: Types for the programmable pin bank
// Assumes: Included constants come from gpp_defs.svh
// Notes: Pad signals travel together as one struct
package gpp_pkg;
	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
		logic [31:0] pull_en;
		logic [31:0] pull_up;
	} gpp_pad_t;

	typedef enum logic [1:0] {
		GPP_ST_WAIT = 2'b00,
		GPP_ST_SAMPLE = 2'b01,
		GPP_ST_RUN = 2'b10
	} gpp_state_t;
endpackage

// >>> gpp_sync.sv
// Purpose: Two-stage synchroniser for a bus of asynchronous inputs
// Assumes: Destination clock pclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module gpp_sync #(
	parameter int WIDTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// >>> gpp_far_pins.sv
// Purpose: Far side of the shared pins: resolves every pad level from all drivers
// Assumes: The bench says which pins the outside world drives and at what level
// Notes: An undriven pin with no pull toggles each cycle, so a stale level never reads as valid
`timescale 1ns/1ns
module gpp_far_pins (
	input wire logic pclk,
	input wire gpp_pkg::gpp_pad_t pad,
	input wire logic [31:0] ext_oe,
	input wire logic [31:0] ext_val,
	input wire logic strap_low,
	output logic [31:0] pin_in,
	output logic addr_strap_n
);
	logic [31:0] float_val = 32'h55555555;
	always @(posedge pclk) begin
		float_val <= ~float_val;
	end
	// The strap pin has a weak pullup, so it reads high unless held low
	assign addr_strap_n = ~strap_low;
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			pin_in[i] = pad.oe[i] ? pad.out[i] : ext_oe[i] ? ext_val[i] :
				pad.pull_en[i] ? pad.pull_up[i] : float_val[i];
		end
	end
endmodule

// >>> test_programmable_io_pin_defaults.sv
// Purpose: Self-checking bench for the programmable pin bank
// Assumes: APB master, 250 MHz pclk, clk_en dropped once in mid-transfer
// Notes: Reference model keeps the registers as integers
`timescale 1ns/1ns
module test_programmable_io_pin_defaults;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strap_low = 0, pready, pslverr, addr_strap_n, err;
	logic clk_en = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, ext_oe = 32'h00000000, ext_val = 32'h00000000, prdata, pin_in, gp_en, rd;
	gpp_pkg::gpp_pad_t pad;
	int n_mismatch = 0, checks = 0;
	int unsigned m_en, m_dir, m_pull, m_out, v;
	initial begin
		forever #2 pclk = ~pclk;
	end
	gpp_bank dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.addr_strap_n(addr_strap_n), .pad(pad), .general_purpose_pin_en(gp_en));
	gpp_far_pins far_u (.pclk(pclk), .pad(pad), .ext_oe(ext_oe), .ext_val(ext_val), .strap_low(strap_low),
		.pin_in(pin_in), .addr_strap_n(addr_strap_n));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	// One idle cycle after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata; err = pslverr;
		if (n >= 20) n_mismatch++;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(name, rd, exp);
		chk("slverr", {31'h0, err}, 32'h00000000);
	endtask
	task automatic chk_pad();
		chk("oe", pad.oe, m_en & m_dir);
		chk("pull_en", pad.pull_en, m_en & ~m_dir);
		chk("pull_up", pad.pull_up & pad.pull_en, m_pull & m_en & ~m_dir);
		chk("out", pad.out & pad.oe, m_out & m_en & m_dir);
		chk("pin_en", gp_en, m_en);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		#80000;
		n_mismatch++;
		conclude();
	end
	initial begin
		void'($urandom(79227));
		for (int s = 0; s < 2; s++) begin
			presetn <= 1'b0; strap_low <= s[0];
			repeat (10) @(posedge pclk);
			presetn <= 1'b1;
			repeat (8) @(posedge pclk);
			// Pins 4..9 keep normal function; a low strap also returns 26 and 29
			m_en = 32'hffffffff & ~(32'h0000003f << 4) & ~(s ? 32'h24000000 : 32'h00000000);
			m_pull = ~32'h00000442; m_dir = 0; m_out = 0;
			rd_chk("enable", 12'h000, m_en);
			rd_chk("dir", 12'h004, m_dir);
			rd_chk("pull", 12'h008, m_pull);
			rd_chk("out", 12'h00c, m_out);
			rd_chk("stat", 12'h014, 32'h00000002 | s);
			chk_pad();
			$display("test reset strap_low=%0d done", s);
		end
		m_en = 32'hffffffff;
		apb(1'b1, 12'h000, m_en);
		chk_pad();
		$display("test normal pins switched to pin mode done");
		for (int i = 0; i < 8; i++) begin
			m_en = $urandom; m_dir = $urandom; m_pull = $urandom; m_out = $urandom;
			apb(1'b1, 12'h000, m_en);
			apb(1'b1, 12'h004, m_dir);
			apb(1'b1, 12'h008, m_pull);
			apb(1'b1, 12'h00c, m_out);
			ext_oe <= ~(m_en & m_dir); ext_val <= $urandom;
			repeat (4) @(posedge pclk);
			chk_pad();
			rd_chk("pull_rb", 12'h008, m_pull);
			rd_chk("in", 12'h010, (m_en & m_dir & m_out) | (~(m_en & m_dir) & ext_val));
		end
		$display("test random configuration done");
		// A DIR write stalls while clk_en is low; pads must keep the old setting until it lands
		v = $urandom;
		fork
			apb(1'b1, 12'h004, v);
			begin
				clk_en <= 1'b0;
				repeat (6) @(posedge pclk);
				chk_pad();
				clk_en <= 1'b1;
			end
		join
		chk("frz_err", {31'h0, err}, 32'h00000000);
		m_dir = v;
		chk_pad();
		rd_chk("dir_frz", 12'h004, m_dir);
		$display("test clock enable freeze done");
		v = $urandom;
		apb(1'b1, 12'h018, v);
		chk("wr_err", {31'h0, err}, 32'h00000001);
		apb(1'b0, 12'hffc, 32'h00000000);
		chk("rd_err", {31'h0, err}, 32'h00000001);
		chk("rd_unmapped", rd, 32'h00000000);
		rd_chk("enable_kept", 12'h000, m_en);
		$display("test unmapped access done");
		conclude();
	end
endmodule
